// ### common/rgbx_pkg.sv
// Package with constants and types for the request/grant bus exchange block.
// Behaviour
// R01: Status 101 read, 110 write, 111 passive.
// R02: Float status lines, held high, while granted.
// R03: Two request/grant lines, first has priority.
// R04: Keeper holds unconnected line high, no request.
// R05: Requester pulls line low one clock.
// R06: One-clock low grant only in T4 or T1.
// R07: Granted state from clock after grant pulse. Code enters it in the grant pulse clock.
// R08: Release pulse ends hold, bus back next.
// R09: Resume in T4, or T1 if idle.
// R10: Exchange is request, grant, release pulses.
// R11: One idle clock after each exchange.
// R12: Memory cycle releases in T4 if requested by T2.
// R13: No release after lower byte of word.
// R14: No release after first interrupt acknowledge.
// R15: No grant while locked instruction executes.
// R16: Idle bus grants and releases next clock.
// R17: Cycle starting within 3 clocks follows cycle rules.
// R18: Status leaves passive in T4, returns T3/Tw. Code leaves passive in T1.
// R19: Status 010 I/O write, 011 halt, 100 fetch.
// R20: Other line ignored during an exchange.
package rgbx_pkg;
	typedef enum logic [2:0] {
		RGBX_CYC_INTA,
		RGBX_CYC_IORD,
		RGBX_CYC_IOWR,
		RGBX_CYC_HALT,
		RGBX_CYC_FETCH,
		RGBX_CYC_MEMRD,
		RGBX_CYC_MEMWR,
		RGBX_CYC_PASSIVE
	} rgbx_cyc_e;
	localparam logic [2:0] RGBX_ST_INTA = 3'h0;
	localparam logic [2:0] RGBX_ST_IORD = 3'h1;
	localparam logic [2:0] RGBX_ST_IOWR = 3'h2;
	localparam logic [2:0] RGBX_ST_HALT = 3'h3;
	localparam logic [2:0] RGBX_ST_FETCH = 3'h4;
	localparam logic [2:0] RGBX_ST_MEMRD = 3'h5;
	localparam logic [2:0] RGBX_ST_MEMWR = 3'h6;
	localparam logic [2:0] RGBX_ST_PASSIVE = 3'h7;
	localparam int RGBX_STATUS_BIT2 = 2;
	localparam int RGBX_STATUS_BIT1 = 1;
	localparam int RGBX_STATUS_BIT0 = 0;
	localparam int RGBX_CYCLE_START_CLOCKS = 3;
	localparam int RGBX_IDLE_CLOCKS = 1;
	typedef enum logic [2:0] {
		RGBX_BUS_TI,
		RGBX_BUS_T1,
		RGBX_BUS_T2,
		RGBX_BUS_T3,
		RGBX_BUS_TW,
		RGBX_BUS_T4
	} rgbx_bus_e;
endpackage

// ### logic/rgbx_exchange.sv
`timescale 1ns/1ps
// Bus exchange and cycle status logic of the local bus interface.
module rgbx_exchange
	import rgbx_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bus_request_grant_high_prio_in,
	input wire logic bus_request_grant_high_prio_oe_in,
	output logic bus_request_grant_high_prio_out,
	output logic bus_request_grant_high_prio_oe,
	input wire logic bus_request_grant_low_prio_in,
	input wire logic bus_request_grant_low_prio_oe_in,
	output logic bus_request_grant_low_prio_out,
	output logic bus_request_grant_low_prio_oe,
	input wire logic cycle_req,
	input wire rgbx_pkg::rgbx_cyc_e cycle_kind,
	input wire logic cycle_word_low,
	input wire logic cycle_inta_first,
	input wire logic cycle_wait,
	input wire logic lock_active,
	output logic cycle_ack,
	output logic cycle_status_bit2,
	output logic cycle_status_bit1,
	output logic cycle_status_bit0,
	output logic cycle_status_oe,
	output logic bus_granted,
	output rgbx_pkg::rgbx_bus_e bus_state
);
	import rgbx_pkg::*;

	typedef enum logic [2:0] {
		RGBX_X_IDLE,
		RGBX_X_PEND,
		RGBX_X_GRANTED,
		RGBX_X_REST
	} rgbx_xchg_e;

	rgbx_xchg_e xchg_r;
	rgbx_bus_e bus_r;
	rgbx_bus_e bus_nxt;
	logic owner_low_r;
	logic req_hi;
	logic req_lo;
	logic grant_hi;
	logic grant_lo;
	logic late_r;
	logic hold_r;
	logic [2:0] status_r;
	logic [2:0] status_nxt;
	logic release_ok;
	logic fire;
	logic release_pulse;
	rgbx_cyc_e kind_r;

	function automatic logic [2:0] rgbx_encode(input rgbx_cyc_e k);
		case (k)
			RGBX_CYC_INTA: rgbx_encode = RGBX_ST_INTA;
			RGBX_CYC_IORD: rgbx_encode = RGBX_ST_IORD;
			RGBX_CYC_IOWR: rgbx_encode = RGBX_ST_IOWR; // R19
			RGBX_CYC_HALT: rgbx_encode = RGBX_ST_HALT; // R19
			RGBX_CYC_FETCH: rgbx_encode = RGBX_ST_FETCH; // R19
			RGBX_CYC_MEMRD: rgbx_encode = RGBX_ST_MEMRD; // R01
			RGBX_CYC_MEMWR: rgbx_encode = RGBX_ST_MEMWR; // R01
			default: rgbx_encode = RGBX_ST_PASSIVE; // R01
		endcase
	endfunction

	rgbx_line u_high
	(
		.clk(clk),
		.rst_b(rst_b),
		.line_in(bus_request_grant_high_prio_in),
		.line_oe_in(bus_request_grant_high_prio_oe_in),
		.grant_fire(grant_hi),
		.req_pulse(req_hi),
		.line_out_r(bus_request_grant_high_prio_out),
		.line_oe_r(bus_request_grant_high_prio_oe)
	);

	rgbx_line u_low
	(
		.clk(clk),
		.rst_b(rst_b),
		.line_in(bus_request_grant_low_prio_in),
		.line_oe_in(bus_request_grant_low_prio_oe_in),
		.grant_fire(grant_lo),
		.req_pulse(req_lo),
		.line_out_r(bus_request_grant_low_prio_out),
		.line_oe_r(bus_request_grant_low_prio_oe)
	);

	// Release is refused after a low word byte, a first acknowledge or while locked.
	assign release_ok = ~lock_active & ~late_r & // R15 R12
		~(bus_r == RGBX_BUS_T4 && (cycle_word_low || cycle_inta_first)); // R13 R14
	// Grants are only placed in T4, idle clocks or a T1 that carries no cycle.
	assign fire = (xchg_r == RGBX_X_PEND) & release_ok &
		(bus_r == RGBX_BUS_T4 || bus_r == RGBX_BUS_TI || // R06 R16
		(bus_r == RGBX_BUS_T1 && !cycle_ack)); // R17
	assign grant_hi = fire & ~owner_low_r;
	assign grant_lo = fire & owner_low_r;
	assign release_pulse = owner_low_r ? req_lo : req_hi; // R08

	// Exchange sequencer: request, grant, granted, one idle clock.
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			xchg_r <= RGBX_X_IDLE;
			owner_low_r <= 1'b0;
		end
		else
		begin
			case (xchg_r)
				RGBX_X_IDLE:
					if (req_hi)
					begin
						xchg_r <= RGBX_X_PEND;
						owner_low_r <= 1'b0; // R03
					end
					else if (req_lo)
					begin
						xchg_r <= RGBX_X_PEND;
						owner_low_r <= 1'b1;
					end
				RGBX_X_PEND:
					if (fire)
						xchg_r <= RGBX_X_GRANTED; // R07
				RGBX_X_GRANTED:
					if (release_pulse)
						xchg_r <= RGBX_X_REST; // R10
				RGBX_X_REST:
					xchg_r <= RGBX_X_IDLE; // R11 R20
				default:
					xchg_r <= RGBX_X_IDLE;
			endcase
		end
	end

	// A request first seen in T3 or Tw waits for the next cycle.
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			late_r <= 1'b0;
		else if (xchg_r == RGBX_X_IDLE && (req_hi || req_lo))
			late_r <= (bus_r == RGBX_BUS_T3 || bus_r == RGBX_BUS_TW); // R12
		else if (bus_r == RGBX_BUS_T1 || bus_r == RGBX_BUS_TI)
			late_r <= 1'b0;
	end

	// Bus state machine; held off the bus while granted.
	always_comb
	begin
		bus_nxt = bus_r;
		case (bus_r)
			RGBX_BUS_TI:
				bus_nxt = RGBX_BUS_TI;
			RGBX_BUS_T1:
				bus_nxt = cycle_ack ? RGBX_BUS_T2 : RGBX_BUS_TI; // R09
			RGBX_BUS_T2:
				bus_nxt = RGBX_BUS_T3;
			RGBX_BUS_T3:
				bus_nxt = cycle_wait ? RGBX_BUS_TW : RGBX_BUS_T4;
			RGBX_BUS_TW:
				bus_nxt = cycle_wait ? RGBX_BUS_TW : RGBX_BUS_T4;
			RGBX_BUS_T4:
				bus_nxt = RGBX_BUS_TI;
			default:
				bus_nxt = RGBX_BUS_TI;
		endcase
		if (fire || hold_r)
			bus_nxt = RGBX_BUS_TI; // R07
		else if (bus_nxt == RGBX_BUS_TI && cycle_req)
			bus_nxt = RGBX_BUS_T1; // R17
		if (hold_r && release_pulse)
			bus_nxt = cycle_req ? RGBX_BUS_T4 : RGBX_BUS_T1; // R09
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			bus_r <= RGBX_BUS_TI;
			hold_r <= 1'b0;
			kind_r <= RGBX_CYC_PASSIVE;
		end
		else
		begin
			bus_r <= bus_nxt;
			if (fire)
				hold_r <= 1'b1; // R07
			else if (hold_r && release_pulse)
				hold_r <= 1'b0; // R08
			if (bus_nxt == RGBX_BUS_T1)
				kind_r <= cycle_kind;
		end
	end

	// Status leaves passive with T1 itself and returns in T3/Tw.
	always_comb
	begin
		status_nxt = RGBX_ST_PASSIVE;
		if (bus_nxt == RGBX_BUS_T1 && !hold_r)
			status_nxt = rgbx_encode(cycle_kind); // R18
		else if (bus_nxt == RGBX_BUS_T2)
			status_nxt = rgbx_encode(kind_r);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			status_r <= RGBX_ST_PASSIVE;
			cycle_status_oe <= 1'b1;
			bus_granted <= 1'b0;
			cycle_ack <= 1'b0;
			bus_state <= RGBX_BUS_TI;
		end
		else
		begin
			status_r <= (fire || hold_r) ? RGBX_ST_PASSIVE : status_nxt; // R02
			cycle_status_oe <= ~(fire || (hold_r && !release_pulse)); // R02
			bus_granted <= fire || (hold_r && !release_pulse);
			cycle_ack <= (bus_nxt == RGBX_BUS_T1) && !(fire || hold_r);
			bus_state <= bus_nxt;
		end
	end

	assign cycle_status_bit2 = status_r[RGBX_STATUS_BIT2];
	assign cycle_status_bit1 = status_r[RGBX_STATUS_BIT1];
	assign cycle_status_bit0 = status_r[RGBX_STATUS_BIT0];
endmodule // rgbx_exchange

// ### logic/rgbx_line.sv
`timescale 1ns/1ps
// One request/grant line: pulse detection, grant drive and keeper.
module rgbx_line
	import rgbx_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic line_in,
	input wire logic line_oe_in,
	input wire logic grant_fire,
	output logic req_pulse,
	output logic line_out_r,
	output logic line_oe_r
);
	logic seen_r;
	logic level;
	// An undriven line is read through the keeper as high.
	assign level = line_in | ~line_oe_in; // R04
	// A falling level marks a pulse from the other master.
	assign req_pulse = seen_r & ~level & ~line_oe_r; // R05
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			seen_r <= 1'b1;
		else if (line_oe_r)
			seen_r <= 1'b1;
		else
			seen_r <= level;
	end
	// The grant is a single-clock low pulse driven by this end.
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			line_out_r <= 1'b1;
			line_oe_r <= 1'b0;
		end
		else
		begin
			line_out_r <= ~grant_fire; // R06
			line_oe_r <= grant_fire; // R10
		end
	end
endmodule // rgbx_line

// ### test/rgbx_assertions.sv
// Assertions on the ports of the bus exchange block.
`timescale 1ns/1ps
module rgbx_assertions
	import rgbx_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bus_request_grant_high_prio_out,
	input wire logic bus_request_grant_high_prio_oe,
	input wire logic bus_request_grant_low_prio_oe,
	input wire rgbx_pkg::rgbx_cyc_e cycle_kind,
	input wire logic lock_active,
	input wire logic cycle_ack,
	input wire logic cycle_status_bit2,
	input wire logic cycle_status_bit1,
	input wire logic cycle_status_bit0,
	input wire logic cycle_status_oe,
	input wire logic bus_granted,
	input wire rgbx_pkg::rgbx_bus_e bus_state
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire hp = bus_request_grant_high_prio_oe;
	wire lp = bus_request_grant_low_prio_oe;
	wire [2:0] st = {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0};
	logic [2:0] kind_r;
	// Holds the kind of the cycle accepted last.
	always_ff @(posedge clk)
	begin
		if (cycle_ack)
			kind_r <= cycle_kind;
	end
	chk_float_when_granted: assert property (bus_granted |-> !cycle_status_oe && st == RGBX_ST_PASSIVE)
		else $error("status driven while granted");
	chk_grant_one_clock: assert property ($rose(hp) |=> !hp)
		else $error("grant pulse longer than a clock");
	chk_grant_drives_low: assert property (hp |-> !bus_request_grant_high_prio_out)
		else $error("grant pulse not low");
	chk_grant_owns_bus: assert property ((hp || lp) |-> bus_granted && !cycle_status_oe)
		else $error("grant without handover");
	chk_single_grant: assert property (!(hp && lp))
		else $error("both lines granted");
	chk_lock_no_grant: assert property (lock_active [*2] |-> !hp && !lp)
		else $error("grant during locked instruction");
	chk_resume_state: assert property ($fell(bus_granted) |-> cycle_status_oe &&
		(bus_state == RGBX_BUS_T1 || bus_state == RGBX_BUS_T4))
		else $error("bad state after reclaim");
	chk_ack_in_t1: assert property (cycle_ack |-> bus_state == RGBX_BUS_T1)
		else $error("cycle accepted outside T1");
	chk_status_code: assert property (bus_state == RGBX_BUS_T2 |-> st == kind_r)
		else $error("status code wrong in T2");
	cover property ($rose(hp));
	cover property ($rose(lp));
	cover property (cycle_ack && cycle_kind == RGBX_CYC_MEMWR);
endmodule // rgbx_assertions

// ### test/rgbx_master_model.sv
// Model of a second local bus master on one request/grant line.
`timescale 1ns/1ps
module rgbx_master_model
(
	input wire logic clk,
	input wire logic line,
	input wire logic start,
	input wire logic [3:0] hold,
	output logic oe,
	output logic out,
	output logic busy,
	output logic got
);
	int n;
	initial
	begin
		oe = 1'b0;
		out = 1'b1;
		busy = 1'b0;
		got = 1'b0;
		forever
		begin
			@(posedge clk);
			if (start === 1'b1)
			begin
				busy <= 1'b1;
				got <= 1'b0;
				oe <= 1'b1;
				out <= 1'b0;
				@(posedge clk);
				oe <= 1'b0;
				out <= 1'b1;
				n = 0;
				do
				begin
					@(posedge clk);
					n++;
				end while (line !== 1'b0 && n < 40);
				if (line === 1'b0)
				begin
					got <= 1'b1;
					repeat (hold) @(posedge clk);
					oe <= 1'b1;
					out <= 1'b0;
					@(posedge clk);
					oe <= 1'b0;
					out <= 1'b1;
				end
				@(posedge clk);
				@(posedge clk);
				busy <= 1'b0;
			end
		end
	end
endmodule // rgbx_master_model

// ### test/testbench.sv
// Self-checking bench for the request/grant bus exchange block.
`timescale 1ns/1ps
`define CHK(nm, e, g) n_checks++; if ((g) !== (e)) begin num_errors++; $display("Error %s expected %0h seen %0h", nm, e, g); end
module testbench;
	import rgbx_pkg::*;
	logic clk, rst_b, cycle_req, cycle_word_low, cycle_inta_first, cycle_wait, lock_active;
	logic cycle_ack, cycle_status_bit2, cycle_status_bit1, cycle_status_bit0, cycle_status_oe;
	logic bus_request_grant_high_prio_oe_in, bus_request_grant_low_prio_oe_in, m0_out, m1_out;
	logic bus_request_grant_high_prio_out, bus_request_grant_high_prio_oe, bus_granted;
	logic bus_request_grant_low_prio_out, bus_request_grant_low_prio_oe;
	wire bus_request_grant_high_prio_in, bus_request_grant_low_prio_in;
	rgbx_cyc_e cycle_kind;
	rgbx_bus_e bus_state;
	logic [1:0] go, ge;
	logic [3:0] hold;
	logic [2:0] ke;
	wire [1:0] busy, got;
	logic [1:0] exp_q[$];
	logic [2:0] kind_q[$];
	int num_errors = 0;
	int n_checks = 0;
	assign bus_request_grant_high_prio_in = bus_request_grant_high_prio_oe ?
		bus_request_grant_high_prio_out : (bus_request_grant_high_prio_oe_in ? m0_out : 1'b1);
	assign bus_request_grant_low_prio_in = bus_request_grant_low_prio_oe ?
		bus_request_grant_low_prio_out : (bus_request_grant_low_prio_oe_in ? m1_out : 1'b1);
	wire [2:0] st = cycle_status_oe ? {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0} : 3'h7;
	rgbx_exchange dut (.*);
	rgbx_master_model m0 (.clk, .line(bus_request_grant_high_prio_in), .start(go[0]), .hold,
		.oe(bus_request_grant_high_prio_oe_in), .out(m0_out), .busy(busy[0]), .got(got[0]));
	rgbx_master_model m1 (.clk, .line(bus_request_grant_low_prio_in), .start(go[1]), .hold,
		.oe(bus_request_grant_low_prio_oe_in), .out(m1_out), .busy(busy[1]), .got(got[1]));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic report_and_stop;
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic run_cycle(input logic [2:0] k);
		int n;
		n = 0;
		@(posedge clk);
		cycle_kind <= rgbx_cyc_e'(k);
		cycle_word_low <= 1'($urandom % 2);
		cycle_inta_first <= 1'($urandom % 2);
		cycle_wait <= 1'($urandom % 2);
		cycle_req <= 1'b1;
		kind_q.push_back(k);
		@(negedge clk);
		while (cycle_ack !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		`CHK("cycle ack", 1'b1, cycle_ack)
		@(posedge clk);
		cycle_req <= 1'b0;
		repeat (2) @(posedge clk);
		cycle_wait <= 1'b0;
	endtask
	task automatic exchange(input logic [1:0] who, input logic [1:0] g);
		@(posedge clk);
		hold <= 4'h1 + 4'($urandom % 8);
		go <= who;
		if (g != 2'h0)
			exp_q.push_back(g);
		@(posedge clk);
		go <= 2'h0;
		repeat (2) @(posedge clk);
		while (busy !== 2'h0) @(posedge clk);
	endtask
	always @(posedge clk)
	begin
		if (rst_b === 1'b1 && (bus_request_grant_high_prio_oe | bus_request_grant_low_prio_oe) === 1'b1)
		begin
			ge = (exp_q.size() > 0) ? exp_q.pop_front() : 2'h0;
			`CHK("grant line", ge, {bus_request_grant_low_prio_oe, bus_request_grant_high_prio_oe})
		end
		if (rst_b === 1'b1 && bus_state === RGBX_BUS_T2)
		begin
			ke = (kind_q.size() > 0) ? kind_q.pop_front() : 3'h7;
			`CHK("status", ke, st)
		end
	end
	initial
	begin
		repeat (4000) @(posedge clk);
		num_errors++;
		report_and_stop;
	end
	initial
	begin
		void'($urandom(12));
		rst_b = 1'b0;
		go = 2'h0;
		hold = 4'h1;
		cycle_req = 1'b0;
		cycle_kind = RGBX_CYC_PASSIVE;
		cycle_word_low = 1'b0;
		cycle_inta_first = 1'b0;
		cycle_wait = 1'b0;
		lock_active = 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		`CHK("status at reset", 3'h7, st)
		for (int k = 0; k < 7; k++)
			run_cycle(k[2:0]);
		exchange(2'h1, 2'h1);
		exchange(2'h3, 2'h1);
		`CHK("low line ignored", 1'b0, got[1])
		@(posedge clk);
		lock_active <= 1'b1;
		fork
			exchange(2'h2, 2'h2);
			begin
				repeat (12) @(posedge clk);
				`CHK("grant under lock", 1'b0, got[1])
				lock_active <= 1'b0;
			end
		join
		fork
			run_cycle(RGBX_ST_MEMRD);
			exchange(2'h1, 2'h1);
		join
		`CHK("grants left", 0, exp_q.size())
		report_and_stop;
	end
endmodule // testbench
bind rgbx_exchange rgbx_assertions chk (.*);
